// ===== logic/ssm_cfg.svh
// Offsets, field positions, reset values and limits of the standstill and speed monitor.
// Contract
// - Standstill check starts once the delay has run out.
// - Ramped stop and stops C, D, E also enter standstill.
// - Entry latches the position as reference until deselection.
// - Deselection clears the delay and releases the drive.
// - Leaving the window gives stop B, then A, and a message.
// - System error in standstill gives stop F and a message.
// - Standstill keeps the drive in closed-loop control.
// - Four limits, switchable while checking runs.
// - A lower limit waits for the changeover delay.
// - Speed above the enforced limit gives a message and the configured stop.
// - Configured stop is A, B, C or D.
// - A higher limit applies at once.
// - Two setpoint limits: selected limit times a percent factor.
// - Two select inputs code limit 0 to 3.
// - Two unacknowledged discrepancies force limit 0.
// - Function 3 behaves as encoder mode; 1 selects brake ramp. Code refuses stops C and D for function 3 as for 1 and 2.
// - Brake ramp: a new lower limit starts quick-stop braking.
// - Ramp checked after ramp delay; violation gives message and stop A.
// - Limit adopted when ramp reaches it or speed stays below it.
// - Encoderless operation allows only stop A or B.
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH
`define SSM_OFF_CTRL      8'h00
`define SSM_OFF_HOLD_DLY  8'h04
`define SSM_OFF_CHG_DLY   8'h08
`define SSM_OFF_TOL       8'h0c
`define SSM_OFF_LIMIT     4'h1
`define SSM_OFF_FACTOR    8'h20
`define SSM_OFF_RAMP_DLY  8'h24
`define SSM_OFF_RAMP_STEP 8'h28
`define SSM_OFF_STATUS    8'h2c
`define SSM_OFF_ACK       8'h30
`define SSM_OFF_EFF       8'h34
`define SSM_CTRL_STOP_LSB 0
`define SSM_CTRL_FUNC_LSB 4
`define SSM_FUNC_RAMP     2'h1
`define SSM_ACK_STOPS     0
`define SSM_ACK_MSGS      1
`define SSM_ACK_DISC      2
`define SSM_RST_CTRL      32'h0000_0000
`define SSM_RST_FACTOR    8'h64
`define SSM_PERCENT       100
`define SSM_DISC_LIMIT    2'h2
`define SSM_STOP_A        0
`define SSM_STOP_B        1
`define SSM_STOP_C        2
`define SSM_STOP_D        3
`define SSM_STOP_E        4
`define SSM_STOP_F        5
`endif

// ===== logic/ssm_pkg.sv
// Types shared by the standstill and speed monitor.
package ssm_pkg;
    typedef enum logic [1:0] {HOLD_IDLE, HOLD_DELAY, HOLD_ACTIVE} ssm_hold_e;
    typedef enum logic [1:0] {SPD_STEADY, SPD_WAIT, SPD_RAMP_DLY, SPD_RAMP_MON} ssm_spd_e;
endpackage

// ===== logic/ssm_monitor.sv
// Standstill hold and limited speed monitor with an APB register slave.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "ssm_cfg.svh"
module ssm_monitor #(
    parameter int POS_W = 32,
    parameter int SPD_W = 16,
    parameter int TMR_W = 24
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             standstill_select_bit,
    input  wire logic             ramped_stop_to_hold,
    input  wire logic             failsafe_input_bit0,
    input  wire logic             failsafe_input_bit1,
    input  wire logic             limited_speed_monitor_en,
    input  wire logic             discrepancy_err,
    input  wire logic             system_error,
    input  wire logic [5:0]       ext_stop_req,
    input  wire logic [POS_W-1:0] actual_pos,
    input  wire logic [SPD_W-1:0] actual_speed,
    output logic      [5:0]       stop_out,
    output logic                  closed_loop_hold,
    output logic                  motion_release,
    output logic                  quick_stop_ramp,
    output logic      [3:0]       msg_out,
    output logic      [SPD_W-1:0] effective_setpoint_limit0,
    output logic      [SPD_W-1:0] effective_setpoint_limit1
);

    // ********
    // Parameter check
    // ********
    generate
        if (SPD_W < 8 || SPD_W > 32 || POS_W > 32 || POS_W < 2 || TMR_W > 32) begin : g_bad
            $error("Unsupported width parameters.");
        end
    endgenerate

    // ********
    // Pin synchronisers
    // ********
    localparam int NPIN = 5;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_q;
    logic [NPIN-1:0] s2_q;
    logic [NPIN-1:0] s3_q;
    logic [NPIN-1:0] pin_q;

    assign pin_raw = {limited_speed_monitor_en, failsafe_input_bit1, failsafe_input_bit0,
                      ramped_stop_to_hold, standstill_select_bit};

    // Each pin passes three flops; a change counts once the last two agree.
    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_q[i]  <= 1'b0;
                    s2_q[i]  <= 1'b0;
                    s3_q[i]  <= 1'b0;
                    pin_q[i] <= 1'b0;
                end else begin
                    s1_q[i] <= pin_raw[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i]) begin
                        pin_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

    // ********
    // Registers
    // ********
    logic [1:0]       stop_sel_q;
    logic [1:0]       func_sel_q;
    logic [TMR_W-1:0] hold_dly_q;
    logic [TMR_W-1:0] chg_dly_q;
    logic [TMR_W-1:0] ramp_dly_q;
    logic [POS_W-1:0] tol_q;
    logic [SPD_W-1:0] lim_q [4];
    logic [7:0]       factor_q;
    logic [SPD_W-1:0] ramp_step_q;
    logic             wr_en;
    logic             acc;
    logic             mapped;
    logic             bad_ctrl;
    logic [2:0]       ack_bits;
    logic             ramp_mode;

    assign acc   = psel & penable;
    assign wr_en = acc & pwrite & ~pslverr;
    assign pready = 1'b1;
    assign ramp_mode = (func_sel_q == `SSM_FUNC_RAMP);

    // Address decode; limits sit in four words from the limit offset.
    always_comb begin
        mapped = 1'b1;
        case (paddr)
            `SSM_OFF_CTRL, `SSM_OFF_HOLD_DLY, `SSM_OFF_CHG_DLY, `SSM_OFF_TOL,
            `SSM_OFF_FACTOR, `SSM_OFF_RAMP_DLY, `SSM_OFF_RAMP_STEP, `SSM_OFF_STATUS,
            `SSM_OFF_ACK, `SSM_OFF_EFF: mapped = 1'b1;
            default: mapped = (paddr[7:4] == `SSM_OFF_LIMIT) && (paddr[1:0] == 2'h0);
        endcase
    end

    // Any nonzero function select refuses stops beyond B.
    assign bad_ctrl = (paddr == `SSM_OFF_CTRL) && pwrite &&
                      (pwdata[`SSM_CTRL_FUNC_LSB +: 2] != 2'h0) &&
                      (pwdata[`SSM_CTRL_STOP_LSB +: 2] > 2'h1);
    assign pslverr  = acc & (~mapped | bad_ctrl);
    assign ack_bits = (wr_en && paddr == `SSM_OFF_ACK) ? pwdata[2:0] : 3'h0;

    // Configuration writes take effect at the access edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_sel_q  <= 2'(`SSM_RST_CTRL);
            func_sel_q  <= 2'h0;
            hold_dly_q  <= '0;
            chg_dly_q   <= '0;
            ramp_dly_q  <= '0;
            tol_q       <= '0;
            factor_q    <= `SSM_RST_FACTOR;
            ramp_step_q <= '0;
            for (int k = 0; k < 4; k++) begin
                lim_q[k] <= '0;
            end
        end else if (wr_en) begin
            case (paddr)
                `SSM_OFF_CTRL: begin
                    stop_sel_q <= pwdata[`SSM_CTRL_STOP_LSB +: 2];
                    func_sel_q <= pwdata[`SSM_CTRL_FUNC_LSB +: 2];
                end
                `SSM_OFF_HOLD_DLY:  hold_dly_q  <= pwdata[TMR_W-1:0];
                `SSM_OFF_CHG_DLY:   chg_dly_q   <= pwdata[TMR_W-1:0];
                `SSM_OFF_RAMP_DLY:  ramp_dly_q  <= pwdata[TMR_W-1:0];
                `SSM_OFF_TOL:       tol_q       <= pwdata[POS_W-1:0];
                `SSM_OFF_FACTOR:    factor_q    <= pwdata[7:0];
                `SSM_OFF_RAMP_STEP: ramp_step_q <= pwdata[SPD_W-1:0];
                default: begin
                    if (paddr[7:4] == `SSM_OFF_LIMIT) begin
                        lim_q[paddr[3:2]] <= pwdata[SPD_W-1:0];
                    end
                end
            endcase
        end
    end

    // ********
    // Standstill hold
    // ********
    ssm_pkg::ssm_hold_e hold_q;
    logic [TMR_W-1:0]   hold_tmr_q;
    logic [POS_W-1:0]   ref_pos_q;
    logic [POS_W-1:0]   pos_diff;
    logic [POS_W-1:0]   pos_abs;
    logic               hold_req;
    logic               hold_viol;
    logic               hold_syserr;
    logic [5:0]         stop_q;

    assign hold_req = pin_q[0] | pin_q[1] | stop_q[`SSM_STOP_C] | stop_q[`SSM_STOP_D] |
                      stop_q[`SSM_STOP_E];

    // Delay, then latch the reference; deselection drops out at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q     <= ssm_pkg::HOLD_IDLE;
            hold_tmr_q <= '0;
            ref_pos_q  <= '0;
        end else begin
            case (hold_q)
                ssm_pkg::HOLD_IDLE: begin
                    if (hold_req) begin
                        hold_q     <= ssm_pkg::HOLD_DELAY;
                        hold_tmr_q <= hold_dly_q;
                    end
                end
                ssm_pkg::HOLD_DELAY: begin
                    if (!hold_req) begin
                        hold_q     <= ssm_pkg::HOLD_IDLE;
                        hold_tmr_q <= '0;
                    end else if (hold_tmr_q == '0) begin
                        hold_q    <= ssm_pkg::HOLD_ACTIVE;
                        ref_pos_q <= actual_pos;
                    end else begin
                        hold_tmr_q <= hold_tmr_q - 1'b1;
                    end
                end
                ssm_pkg::HOLD_ACTIVE: begin
                    if (!hold_req) begin
                        hold_q <= ssm_pkg::HOLD_IDLE;
                    end
                end
                default: hold_q <= ssm_pkg::HOLD_IDLE;
            endcase
        end
    end

    // Signed distance from the reference against the tolerance window.
    assign pos_diff    = actual_pos - ref_pos_q;
    assign pos_abs     = pos_diff[POS_W-1] ? (~pos_diff + 1'b1) : pos_diff;
    assign hold_viol   = (hold_q == ssm_pkg::HOLD_ACTIVE) && (pos_abs > tol_q);
    assign hold_syserr = (hold_q == ssm_pkg::HOLD_ACTIVE) && system_error;
    assign closed_loop_hold = (hold_q != ssm_pkg::HOLD_IDLE);
    assign motion_release   = (hold_q == ssm_pkg::HOLD_IDLE);

    // ********
    // Limit selection and changeover
    // ********
    ssm_pkg::ssm_spd_e spd_q;
    logic [1:0]        disc_cnt_q;
    logic [1:0]        tgt_idx;
    logic [1:0]        cur_idx_q;
    logic [1:0]        new_idx_q;
    logic [TMR_W-1:0]  spd_tmr_q;
    logic [TMR_W-1:0]  below_q;
    logic [SPD_W-1:0]  ramp_val_q;
    logic              lim_ev;
    logic              ramp_ev;
    logic              ramping;

    // Discrepancy counter saturates at its limit until acknowledged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disc_cnt_q <= 2'h0;
        end else if (discrepancy_err && disc_cnt_q != `SSM_DISC_LIMIT) begin
            disc_cnt_q <= disc_cnt_q + 1'b1;
        end else if (ack_bits[`SSM_ACK_DISC] && !discrepancy_err) begin
            disc_cnt_q <= 2'h0;
        end
    end

    assign tgt_idx = (disc_cnt_q == `SSM_DISC_LIMIT) ? 2'h0 :
                     {pin_q[3], pin_q[2]};
    assign ramping = (spd_q == ssm_pkg::SPD_RAMP_DLY) || (spd_q == ssm_pkg::SPD_RAMP_MON);
    assign quick_stop_ramp = ramping;

    // Changeover sequencer: old limit stays in force until adoption.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_q      <= ssm_pkg::SPD_STEADY;
            cur_idx_q  <= 2'h0;
            new_idx_q  <= 2'h0;
            spd_tmr_q  <= '0;
            below_q    <= '0;
            ramp_val_q <= '0;
        end else begin
            case (spd_q)
                ssm_pkg::SPD_STEADY: begin
                    if (tgt_idx != cur_idx_q) begin
                        new_idx_q <= tgt_idx;
                        below_q   <= '0;
                        if (!pin_q[4] || lim_q[tgt_idx] >= lim_q[cur_idx_q]) begin
                            cur_idx_q <= tgt_idx;
                        end else if (ramp_mode) begin
                            spd_q      <= ssm_pkg::SPD_RAMP_DLY;
                            spd_tmr_q  <= ramp_dly_q;
                            ramp_val_q <= actual_speed;
                        end else begin
                            spd_q     <= ssm_pkg::SPD_WAIT;
                            spd_tmr_q <= chg_dly_q;
                        end
                    end
                end
                ssm_pkg::SPD_WAIT: begin
                    if (tgt_idx != new_idx_q) begin
                        spd_q <= ssm_pkg::SPD_STEADY;
                    end else if (spd_tmr_q == '0) begin
                        cur_idx_q <= new_idx_q;
                        spd_q     <= ssm_pkg::SPD_STEADY;
                    end else begin
                        spd_tmr_q <= spd_tmr_q - 1'b1;
                    end
                end
                ssm_pkg::SPD_RAMP_DLY, ssm_pkg::SPD_RAMP_MON: begin
                    ramp_val_q <= (ramp_val_q > ramp_step_q) ? ramp_val_q - ramp_step_q : '0;
                    below_q <= (actual_speed < lim_q[new_idx_q]) ? below_q + 1'b1 : '0;
                    if (spd_q == ssm_pkg::SPD_RAMP_DLY) begin
                        if (spd_tmr_q == '0) begin
                            spd_q <= ssm_pkg::SPD_RAMP_MON;
                        end else begin
                            spd_tmr_q <= spd_tmr_q - 1'b1;
                        end
                    end
                    if (tgt_idx != new_idx_q) begin
                        spd_q <= ssm_pkg::SPD_STEADY;
                    end else if ((spd_q == ssm_pkg::SPD_RAMP_MON &&
                                  ramp_val_q <= lim_q[new_idx_q]) ||
                                 (below_q >= ramp_dly_q &&
                                  actual_speed < lim_q[new_idx_q])) begin
                        cur_idx_q <= new_idx_q;
                        spd_q     <= ssm_pkg::SPD_STEADY;
                    end
                end
                default: spd_q <= ssm_pkg::SPD_STEADY;
            endcase
        end
    end

    // Continuous check against the enforced limit and the ramp.
    assign lim_ev  = pin_q[4] && (actual_speed > lim_q[cur_idx_q]);
    assign ramp_ev = (spd_q == ssm_pkg::SPD_RAMP_MON) && (actual_speed > ramp_val_q);

    // Setpoint limits follow the selected limit scaled by the factor.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            effective_setpoint_limit0 <= '0;
            effective_setpoint_limit1 <= '0;
        end else begin
            effective_setpoint_limit0 <= SPD_W'(({8'h00, lim_q[tgt_idx]} * factor_q) /
                                                `SSM_PERCENT);
            effective_setpoint_limit1 <= SPD_W'(({8'h00, lim_q[tgt_idx]} * factor_q) /
                                                `SSM_PERCENT);
        end
    end

    // ********
    // Stop requests and messages
    // ********
    logic [5:0] stop_set;
    logic [5:0] stop_d;
    logic [3:0] msg_set;

    // Gather the stop sources; stop B escalates to A once speed is zero.
    always_comb begin
        stop_set = ext_stop_req;
        stop_set[`SSM_STOP_A] = ext_stop_req[`SSM_STOP_A] | ramp_ev |
                                (stop_q[`SSM_STOP_B] && actual_speed == '0);
        stop_set[`SSM_STOP_B] = ext_stop_req[`SSM_STOP_B] | hold_viol;
        stop_set[`SSM_STOP_F] = ext_stop_req[`SSM_STOP_F] | hold_syserr;
        if (lim_ev) begin
            stop_set[stop_sel_q] = 1'b1;
        end
        stop_d = stop_set | (stop_q & ~{6{ack_bits[`SSM_ACK_STOPS]}});
    end

    assign msg_set = {ramp_ev, lim_ev, hold_syserr, hold_viol};

    // Sticky flags; a new event beats an acknowledge in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_q   <= 6'h00;
            stop_out <= 6'h00;
            msg_out  <= 4'h0;
        end else begin
            stop_q   <= stop_d;
            stop_out <= stop_d & (~stop_d + 6'h01);
            msg_out  <= msg_set | (msg_out & ~{4{ack_bits[`SSM_ACK_MSGS]}});
        end
    end

    // ********
    // Read data
    // ********
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `SSM_OFF_CTRL: begin
                    prdata[`SSM_CTRL_STOP_LSB +: 2] <= stop_sel_q;
                    prdata[`SSM_CTRL_FUNC_LSB +: 2] <= func_sel_q;
                end
                `SSM_OFF_HOLD_DLY:  prdata[TMR_W-1:0] <= hold_dly_q;
                `SSM_OFF_CHG_DLY:   prdata[TMR_W-1:0] <= chg_dly_q;
                `SSM_OFF_RAMP_DLY:  prdata[TMR_W-1:0] <= ramp_dly_q;
                `SSM_OFF_TOL:       prdata[POS_W-1:0] <= tol_q;
                `SSM_OFF_FACTOR:    prdata[7:0]       <= factor_q;
                `SSM_OFF_RAMP_STEP: prdata[SPD_W-1:0] <= ramp_step_q;
                `SSM_OFF_STATUS: begin
                    prdata[21:0] <= {disc_cnt_q, spd_q, hold_q, new_idx_q, cur_idx_q, tgt_idx,
                                     msg_out, stop_out};
                end
                `SSM_OFF_EFF: prdata[SPD_W-1:0] <= effective_setpoint_limit0;
                default: begin
                    if (paddr[7:4] == `SSM_OFF_LIMIT) begin
                        prdata[SPD_W-1:0] <= lim_q[paddr[3:2]];
                    end
                end
            endcase
        end
    end

endmodule

// ===== test/ssm_chk_monitor.sv
// Port checker of the standstill and speed monitor.
`timescale 1ns/10ps
module ssm_chk_monitor #(
    parameter int SPD_W = 16
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pslverr,
    input wire logic [5:0]       ext_stop_req,
    input wire logic [5:0]       stop_out,
    input wire logic             closed_loop_hold,
    input wire logic             motion_release,
    input wire logic [3:0]       msg_out,
    input wire logic [SPD_W-1:0] effective_setpoint_limit0,
    input wire logic [SPD_W-1:0] effective_setpoint_limit1
);
    // ********
    // Assertions
    // ********
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic ack_wr;
    // Access-phase write to the acknowledge word.
    assign ack_wr = psel && penable && pwrite && paddr == 8'h30;
    property p_onehot; $onehot0(stop_out); endproperty
    a_onehot: assert property (p_onehot) else $error("stop not one-hot");
    property p_hold_rel; closed_loop_hold != motion_release; endproperty
    a_hold_rel: assert property (p_hold_rel) else $error("hold and release agree");
    property p_eff; effective_setpoint_limit0 == effective_setpoint_limit1; endproperty
    a_eff: assert property (p_eff) else $error("setpoint limits differ");
    property p_msg_keep; |($past(msg_out) & ~msg_out) |-> $past(ack_wr && pwdata[1]); endproperty
    a_msg_keep: assert property (p_msg_keep) else $error("message lost");
    property p_stop_keep; |$past(stop_out) && stop_out == 6'h00 |-> $past(ack_wr && pwdata[0]);
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("stop lost");
    property p_tol; $rose(msg_out[0]) |-> $past(closed_loop_hold); endproperty
    a_tol: assert property (p_tol) else $error("window message outside hold");
    property p_ext_a; ext_stop_req[0] |-> ##[1:2] stop_out == 6'h01; endproperty
    a_ext_a: assert property (p_ext_a) else $error("stop A not shown");
    property p_stop_d; ext_stop_req[3] |-> ##[1:3] closed_loop_hold; endproperty
    a_stop_d: assert property (p_stop_d) else $error("stop D did not hold");
    property p_refuse; psel && penable && pwrite && paddr == 8'h00 && pwdata[5:4] != 2'h0
        && pwdata[1:0] > 2'h1 |-> pslverr; endproperty
    a_refuse: assert property (p_refuse) else $error("bad stop accepted");
endmodule

// ===== test/ssm_partner.sv
// Model of the standstill select and limit select pins and the motion controller.
`timescale 1ns/10ps
module ssm_partner (
    input  wire logic        pclk,
    input  wire logic        hold_req,
    input  wire logic [1:0]  level_req,
    input  wire logic [15:0] speed_cmd,
    input  wire logic        quick_stop_ramp,
    output logic             standstill_select_bit,
    output logic             failsafe_input_bit0,
    output logic             failsafe_input_bit1,
    output logic [15:0]      actual_speed
);
    logic [15:0] target;
    // Halt on hold select and on quick stop brakes the axis to rest.
    assign target = (hold_req || quick_stop_ramp) ? 16'h0000 : speed_cmd;
    // Pins start low and the speed slews four units a cycle.
    initial {standstill_select_bit, failsafe_input_bit1, failsafe_input_bit0, actual_speed} = '0;
    always @(posedge pclk) begin
        standstill_select_bit <= hold_req;
        {failsafe_input_bit1, failsafe_input_bit0} <= level_req;
        if (actual_speed + 16'h0004 < target) actual_speed <= actual_speed + 16'h0004;
        else if (actual_speed > target + 16'h0004) actual_speed <= actual_speed - 16'h0004;
        else actual_speed <= target;
    end
endmodule

// ===== test/tb_top.sv
// Testbench of the standstill and speed monitor.
`timescale 1ns/10ps
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv_err;
    logic        lsm_en, disc_err, sys_err, hold_req, quick_stop_ramp, closed_loop_hold, ramp_stop;
    logic        motion_release, standstill_select_bit, failsafe_input_bit0, failsafe_input_bit1;
    logic [1:0]  level_req;
    logic [3:0]  msg_out;
    logic [5:0]  ext_stop, stop_out;
    logic [7:0]  paddr;
    logic [15:0] speed_cmd, actual_speed, eff0, eff1;
    logic [31:0] pwdata, prdata, rd, actual_pos;
    int          mismatches, comparisons;
    // ********
    // Design, partner and checks
    // ********
    ssm_monitor dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .standstill_select_bit, .ramped_stop_to_hold(ramp_stop),
        .failsafe_input_bit0, .failsafe_input_bit1, .limited_speed_monitor_en(lsm_en),
        .discrepancy_err(disc_err), .system_error(sys_err), .ext_stop_req(ext_stop),
        .actual_pos, .actual_speed, .stop_out, .closed_loop_hold, .motion_release,
        .quick_stop_ramp, .msg_out, .effective_setpoint_limit0(eff0),
        .effective_setpoint_limit1(eff1));
    ssm_partner u_partner (.pclk, .hold_req, .level_req, .speed_cmd, .quick_stop_ramp,
        .standstill_select_bit, .failsafe_input_bit0, .failsafe_input_bit1, .actual_speed);
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error are taken at the completing edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv_err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic results;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Reset state, an unmapped read, limits and setpoint outputs.
    task automatic t_limits;
        chk(32'({stop_out, motion_release}), 32'h01);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h64);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'({rd, slv_err}), 32'h1);
        for (int i = 0; i < 4; i++) apb(1'b1, 8'h10 + 8'(4 * i), 32'(100 * (i + 1)));
        apb(1'b1, 8'h20, 32'd50);
        for (int i = 0; i < 4; i++) begin
            level_req <= 2'(i);
            cyc(10);
            chk(32'(eff0), 32'(50 * (i + 1)));
        end
        $display("limits done");
    endtask
    // Overspeed after a drop to the lowest limit, once per configured stop.
    task automatic t_lower;
        apb(1'b1, 8'h08, 32'd20);
        apb(1'b1, 8'h04, 32'd10);
        speed_cmd <= 16'd250;
        cyc(70);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 8'h00, 32'(s));
            level_req <= 2'h3;
            cyc(12);
            apb(1'b1, 8'h30, 32'h3);
            level_req <= 2'h0;
            cyc(12);
            chk(32'(msg_out[2]), 32'h0);
            cyc(40);
            chk(32'({msg_out[2], stop_out}), 32'h40 | 32'(1 << s));
            chk(32'(closed_loop_hold), 32'(s > 1));
        end
        level_req <= 2'h3;
        cyc(12);
        apb(1'b1, 8'h30, 32'h7);
        repeat (2) begin
            disc_err <= 1'b1;
            cyc(1);
            disc_err <= 1'b0;
            cyc(1);
        end
        cyc(4);
        chk(32'(eff0), 32'd50);
        ext_stop <= 6'h09;
        cyc(1);
        ext_stop <= 6'h00;
        cyc(4);
        chk(32'({stop_out, closed_loop_hold}), 32'h03);
        apb(1'b1, 8'h30, 32'h7);
        $display("lower done");
    endtask
    // Brake-ramp changeover with refused stop codes.
    task automatic t_ramp;
        apb(1'b1, 8'h00, 32'h11);
        apb(1'b1, 8'h00, 32'h12);
        chk(32'(slv_err), 32'h1);
        apb(1'b1, 8'h00, 32'h32);
        chk(32'(slv_err), 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h11);
        apb(1'b1, 8'h24, 32'd10);
        apb(1'b1, 8'h28, 32'd2);
        apb(1'b1, 8'h30, 32'h7);
        speed_cmd <= 16'd50;
        level_req <= 2'h0;
        cyc(8);
        chk(32'(quick_stop_ramp), 32'h1);
        cyc(120);
        chk(32'({quick_stop_ramp, msg_out}), 32'h0);
        $display("ramp done");
    endtask
    // Standstill delay, reference capture, violation, error and release.
    task automatic t_hold;
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h0c, 32'd5);
        apb(1'b1, 8'h04, 32'd30);
        hold_req <= 1'b1;
        cyc(10);
        chk(32'({closed_loop_hold, motion_release}), 32'h2);
        actual_pos <= 32'd1020;
        cyc(40);
        actual_pos <= 32'd1023;
        cyc(5);
        chk(32'(msg_out), 32'h0);
        actual_pos <= 32'd1030;
        cyc(5);
        chk(32'({msg_out, stop_out}), 32'h41);
        sys_err <= 1'b1;
        cyc(1);
        sys_err <= 1'b0;
        cyc(3);
        chk(32'(msg_out[1]), 32'h1);
        hold_req <= 1'b0;
        apb(1'b1, 8'h30, 32'h7);
        cyc(8);
        chk(32'(motion_release), 32'h1);
        ramp_stop <= 1'b1;
        cyc(8);
        chk(32'(closed_loop_hold), 32'h1);
        ramp_stop <= 1'b0;
        $display("hold done");
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Main sequence after a three-cycle reset.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, lsm_en, disc_err, sys_err} = '0;
        {hold_req, ramp_stop, ext_stop, level_req, speed_cmd, mismatches, comparisons} = '0;
        actual_pos = 32'd1000;
        cyc(3);
        presetn <= 1'b1;
        lsm_en <= 1'b1;
        t_limits;
        t_lower;
        t_ramp;
        t_hold;
        results;
    end
    // Watchdog well beyond the roughly 700 cycles the tests take.
    initial begin
        cyc(20000);
        mismatches++;
        results;
    end
endmodule
bind ssm_monitor ssm_chk_monitor #(.SPD_W(SPD_W)) u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pslverr, .ext_stop_req, .stop_out, .closed_loop_hold,
    .motion_release, .msg_out, .effective_setpoint_limit0, .effective_setpoint_limit1);
